// >>> include/fmsp_pkg.sv
// Constants and types shared by the four-mode serial port
package fmsp_pkg;
  localparam int unsigned WORD_W = 9;
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_UART9_FIX = 2'h2;
  localparam logic [1:0] MODE_UART9_VAR = 2'h3;
  localparam logic [2:0] SYNC_DIV_LAST = 3'h5;
  localparam logic [2:0] SYNC_CLK_HIGH = 3'h3;
  localparam logic [2:0] SYNC_CNT_RESET = 3'h0;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_RESET = 4'h0;
  localparam logic [11:0] GEN_TOP = 12'hFFF;
  localparam logic [11:0] GEN_RESET = 12'h000;
  localparam logic [3:0] BITS_SYNC = 4'h8;
  localparam logic [3:0] BITS_UART8 = 4'hA;
  localparam logic [3:0] BITS_UART9 = 4'hB;
  localparam logic [3:0] RX_BITS_UART8 = 4'h9;
  localparam logic [3:0] RX_BITS_UART9 = 4'hA;
  localparam logic [3:0] BIT_LAST = 4'h1;
  localparam logic [3:0] BITS_NONE = 4'h0;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic START_BIT = 1'b0;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_ASYNC = 2'b01, TX_SYNC = 2'b10} fmsp_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_ASYNC = 2'b10, RX_SYNC = 2'b11} fmsp_rx_state_t;
endpackage : fmsp_pkg

// >>> include/fmsp_stream_if.sv
// Valid/ready word stream between the port and its buffer
`timescale 1ns/10ps
`default_nettype none
interface fmsp_stream_if;
  import fmsp_pkg::*;
  logic [WORD_W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : fmsp_stream_if
`default_nettype wire

// >>> src/fmsp_two_entry_buf.sv
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module fmsp_two_entry_buf
  import fmsp_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Streams
  fmsp_stream_if.snk in_s,
  fmsp_stream_if.src out_s
);
  logic [WORD_W-1:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] fill_r;
  logic push;
  logic pop;

  assign in_s.ready = (fill_r != BUF_FULL);
  assign out_s.valid = (fill_r != BUF_EMPTY);
  assign out_s.data = mem_r[rd_ptr_r];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  // Storage needs no reset; fill count guards it
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_s.data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      fill_r <= BUF_EMPTY;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ push;
      rd_ptr_r <= rd_ptr_r ^ pop;
      fill_r <= fill_r + {1'b0, push} - {1'b0, pop};
    end
  end

  buf_fill_bound_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    fill_r <= BUF_FULL) else $error("buffer fill above two");
  buf_full_stall_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (fill_r == BUF_FULL && !pop) |=> (fill_r == BUF_FULL && !in_s.ready)) else $error("full buffer took word");
endmodule : fmsp_two_entry_buf
`default_nettype wire

// >>> src/fmsp_serial_port.sv
// Four-mode serial port, full-duplex in modes 1-3 and half-duplex in mode 0, with ninth-bit address filter
`timescale 1ns/10ps
`default_nettype none
module fmsp_serial_port
  import fmsp_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Control
  input wire logic [1:0] i_mode,
  input wire logic i_receive_enable,
  input wire logic i_multiprocessor_filter_bit,
  input wire logic i_transmit_ninth_bit,
  input wire logic i_baud_double_bit,
  input wire logic i_generator_select_bit,
  input wire logic [7:0] i_prescaler_reload_low,
  input wire logic [3:0] i_prescaler_reload_high,
  input wire logic i_prescaler_load,
  input wire logic i_timer1_overflow,
  // Data register
  input wire logic i_data_wr,
  input wire logic [7:0] i_data_wdata,
  output logic o_data_wr_ready,
  output logic [7:0] o_serial_data_buffer,
  output logic o_received_ninth_bit,
  // Flags
  output logic o_receive_complete_flag,
  output logic o_transmit_complete_flag,
  input wire logic i_receive_flag_clr,
  input wire logic i_transmit_flag_clr,
  output logic o_receive_overrun,
  // Serial pins
  input wire logic i_rxd,
  output logic o_rxd,
  output logic o_rxd_oe,
  output logic o_txd
);
  function automatic logic [10:0] tx_frame(input logic [1:0] mode, input logic [WORD_W-1:0] word);
    if (mode == MODE_SHIFT) begin
      tx_frame = {{3{LINE_IDLE}}, word[7:0]};
    end else if (mode == MODE_UART8) begin
      tx_frame = {LINE_IDLE, LINE_IDLE, word[7:0], START_BIT};
    end else begin
      tx_frame = {LINE_IDLE, word, START_BIT};
    end
  endfunction : tx_frame

  function automatic logic [3:0] frame_len(input logic [1:0] mode, input logic rx);
    if (mode == MODE_SHIFT) begin
      frame_len = BITS_SYNC;
    end else if (mode == MODE_UART8) begin
      frame_len = rx ? RX_BITS_UART8 : BITS_UART8;
    end else begin
      frame_len = rx ? RX_BITS_UART9 : BITS_UART9;
    end
  endfunction : frame_len

  // Aligns the shifter to {ninth, data}; mode 1 ninth is the stop bit
  function automatic logic [WORD_W-1:0] rx_word(input logic [1:0] mode, input logic [9:0] vec);
    if (mode == MODE_SHIFT) begin
      rx_word = {1'b0, vec[9:2]};
    end else if (mode == MODE_UART8) begin
      rx_word = vec[9:1];
    end else begin
      rx_word = vec[8:0];
    end
  endfunction : rx_word

  logic baud_dbl_r;
  logic gen_sel_r;
  logic [11:0] gen_cnt_r;
  logic gen_ovf;
  logic src_pulse;
  logic half_r;
  logic tick16;
  logic [2:0] sync_cnt_r;
  logic sync_tick;
  fmsp_tx_state_t tx_state_r;
  logic [10:0] tx_shift_r;
  logic [3:0] tx_left_r;
  logic [3:0] tx_os_r;
  logic tx_launch;
  logic tx_step;
  logic tx_done;
  fmsp_rx_state_t rx_state_r;
  logic [9:0] rx_shift_r;
  logic [9:0] rx_next;
  logic [3:0] rx_left_r;
  logic [3:0] rx_os_r;
  logic rx_step;
  logic rx_done;
  logic [WORD_W-1:0] rx_got;
  logic rx_take;
  logic rx_load;
  logic rx_flag_r;
  logic tx_flag_r;
  logic overrun_r;
  logic [7:0] rx_data_r;
  logic rx_ninth_r;

  fmsp_stream_if wr_if();
  fmsp_stream_if tx_if();

  // Rate controls start cleared
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      baud_dbl_r <= CTRL_RESET;
      gen_sel_r <= CTRL_RESET;
    end else begin
      baud_dbl_r <= i_baud_double_bit;
      gen_sel_r <= i_generator_select_bit;
    end
  end

  assign gen_ovf = (gen_cnt_r == GEN_TOP);

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gen_cnt_r <= GEN_RESET;
    end else if (i_prescaler_load || gen_ovf) begin
      gen_cnt_r <= {i_prescaler_reload_high, i_prescaler_reload_low};
    end else begin
      gen_cnt_r <= gen_cnt_r + 12'h001;
    end
  end

  always_comb begin
    unique case (i_mode)
      MODE_SHIFT: src_pulse = 1'b0;
      MODE_UART9_FIX: src_pulse = 1'b1;
      MODE_UART8, MODE_UART9_VAR: src_pulse = gen_sel_r ? gen_ovf : i_timer1_overflow;
    endcase
  end

  // Divide-by-two unless doubled; tick16 is the sixteen-times clock
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      half_r <= 1'b0;
    end else if (src_pulse) begin
      half_r <= ~half_r;
    end
  end
  assign tick16 = src_pulse & (baud_dbl_r | half_r);

  assign sync_tick = (sync_cnt_r == SYNC_DIV_LAST);

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_cnt_r <= SYNC_CNT_RESET;
    end else begin
      sync_cnt_r <= sync_tick ? SYNC_CNT_RESET : sync_cnt_r + 3'h1;
    end
  end

  // Writes queue in the buffer so a busy shifter loses nothing
  assign wr_if.data = {i_transmit_ninth_bit, i_data_wdata};
  assign wr_if.valid = i_data_wr;
  assign o_data_wr_ready = wr_if.ready;

  fmsp_two_entry_buf u_tx_buf (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .in_s(wr_if),
    .out_s(tx_if)
  );

  // Mode 0 shares the data pin, so launch waits out a sync receive
  assign tx_launch = (tx_state_r == TX_IDLE) && tx_if.valid
                     && (i_mode != MODE_SHIFT || (sync_tick && rx_state_r != RX_SYNC));
  assign tx_if.ready = tx_launch;
  assign tx_step = (tx_state_r == TX_ASYNC) ? (tick16 && tx_os_r == OVS_LAST)
                                            : (tx_state_r == TX_SYNC && sync_tick);
  assign tx_done = tx_step && (tx_left_r == BIT_LAST);

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= {11{LINE_IDLE}};
      tx_left_r <= BITS_NONE;
      tx_os_r <= OVS_RESET;
    end else begin
      unique case (tx_state_r)
        TX_IDLE: begin
          if (tx_launch) begin
            tx_shift_r <= tx_frame(i_mode, tx_if.data);
            tx_left_r <= frame_len(i_mode, 1'b0);
            tx_os_r <= OVS_RESET;
            tx_state_r <= (i_mode == MODE_SHIFT) ? TX_SYNC : TX_ASYNC;
          end
        end
        TX_ASYNC, TX_SYNC: begin
          if (tick16) begin
            tx_os_r <= tx_os_r + 4'h1;
          end
          if (tx_step) begin
            tx_shift_r <= {LINE_IDLE, tx_shift_r[10:1]};
            tx_left_r <= tx_left_r - 4'h1;
            if (tx_done) begin
              tx_state_r <= TX_IDLE;
            end
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // Pins: mode 0 drives data on the data pin and the shift clock on txd
  assign o_rxd = tx_shift_r[0];
  assign o_rxd_oe = (tx_state_r == TX_SYNC);
  assign o_txd = (tx_state_r == TX_SYNC || rx_state_r == RX_SYNC) ? (sync_cnt_r >= SYNC_CLK_HIGH)
               : (tx_state_r == TX_ASYNC) ? tx_shift_r[0] : LINE_IDLE;

  // Receiver keeps its own shifter, independent of the transmitter
  assign rx_next = {i_rxd, rx_shift_r[9:1]};
  assign rx_step = (rx_state_r == RX_ASYNC) ? (tick16 && rx_os_r == OVS_LAST)
                                            : (rx_state_r == RX_SYNC && sync_cnt_r == SYNC_CLK_HIGH);
  assign rx_done = rx_step && (rx_left_r == BIT_LAST);
  assign rx_got = rx_word(i_mode, rx_next);
  // Filter: mode 0 ignores it, mode 1 needs stop high, modes 2/3 need ninth
  assign rx_take = rx_done && (i_mode == MODE_SHIFT || !i_multiprocessor_filter_bit || rx_got[8]);
  assign rx_load = rx_take && !rx_flag_r;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_state_r <= RX_IDLE;
      rx_shift_r <= {10{LINE_IDLE}};
      rx_left_r <= BITS_NONE;
      rx_os_r <= OVS_RESET;
    end else begin
      unique case (rx_state_r)
        RX_IDLE: begin
          if (i_receive_enable) begin
            if (i_mode == MODE_SHIFT) begin
              if (!rx_flag_r && sync_tick && tx_state_r == TX_IDLE && !tx_if.valid) begin
                rx_left_r <= BITS_SYNC;
                rx_state_r <= RX_SYNC;
              end
            end else if (tick16 && i_rxd == START_BIT) begin
              rx_os_r <= OVS_RESET;
              rx_state_r <= RX_START;
            end
          end
        end
        RX_START: begin
          if (tick16) begin
            rx_os_r <= rx_os_r + 4'h1;
            if (rx_os_r == OVS_MID) begin
              // A glitch shorter than half a bit is no start bit
              rx_os_r <= OVS_RESET;
              rx_left_r <= frame_len(i_mode, 1'b1);
              rx_state_r <= (i_rxd == START_BIT) ? RX_ASYNC : RX_IDLE;
            end
          end
        end
        RX_ASYNC, RX_SYNC: begin
          if (tick16) begin
            rx_os_r <= rx_os_r + 4'h1;
          end
          if (rx_step) begin
            rx_shift_r <= rx_next;
            rx_left_r <= rx_left_r - 4'h1;
            if (rx_done) begin
              rx_state_r <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Holding register: an unread byte wins, the newer one is dropped
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_data_r <= DATA_RESET;
      rx_ninth_r <= CTRL_RESET;
    end else if (rx_load) begin
      rx_data_r <= rx_got[7:0];
      if (i_mode != MODE_SHIFT) begin
        rx_ninth_r <= rx_got[8];
      end
    end
  end

  // Set beats a clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_flag_r <= CTRL_RESET;
      tx_flag_r <= CTRL_RESET;
      overrun_r <= CTRL_RESET;
    end else begin
      rx_flag_r <= rx_load | (rx_flag_r & ~i_receive_flag_clr);
      tx_flag_r <= tx_done | (tx_flag_r & ~i_transmit_flag_clr);
      overrun_r <= rx_take & rx_flag_r;
    end
  end

  assign o_serial_data_buffer = rx_data_r;
  assign o_received_ninth_bit = rx_ninth_r;
  assign o_receive_complete_flag = rx_flag_r;
  assign o_transmit_complete_flag = tx_flag_r;
  assign o_receive_overrun = overrun_r;

  tx_flag_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    tx_done |=> o_transmit_complete_flag) else $error("transmit flag not set at frame end");
  rx_load_data_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    rx_load |=> (o_serial_data_buffer == $past(rx_got[7:0]) && o_receive_complete_flag))
    else $error("received byte not loaded");
  rx_unread_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (rx_take && rx_flag_r) |=> ($stable(o_serial_data_buffer) && o_receive_overrun))
    else $error("unread byte overwritten");
  mp_filter_block_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (rx_done && i_mode[1] && i_multiprocessor_filter_bit && !rx_got[8] && !rx_flag_r)
    |=> !o_receive_complete_flag) else $error("filtered data byte raised flag");
  sync_period_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    sync_tick |-> ##6 sync_tick) else $error("shift rate not one sixth");
  tx_start_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (tx_launch && i_mode != MODE_SHIFT) |=> (o_txd == START_BIT)[*4])
    else $error("start bit not low");
  rx_disabled_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (rx_state_r == RX_IDLE && !i_receive_enable) |=> rx_state_r == RX_IDLE)
    else $error("reception without enable");
  gen_reload_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (gen_ovf && !i_prescaler_load && $stable({i_prescaler_reload_high, i_prescaler_reload_low}))
    |=> gen_cnt_r == {i_prescaler_reload_high, i_prescaler_reload_low}) else $error("generator missed reload");
  mode2_half_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_mode == MODE_UART9_FIX && !baud_dbl_r && !i_baud_double_bit && tick16 && $stable(i_mode)) |=> !tick16)
    else $error("mode 2 rate not halved");
endmodule : fmsp_serial_port
`default_nettype wire

// >>> bench/fmsp_remote_node.sv
// Far-side serial node: sends frames on the line and captures frames from it
`timescale 1ns/10ps
`default_nettype none
module fmsp_remote_node (
  // Clock
  input wire logic i_clk,
  // Serial line
  input wire logic i_line,
  output logic o_line
);
  initial o_line = 1'b1;

  // Frame bits in wire order: start first, stop last
  task automatic send(input logic [10:0] frm, input int nbits, input int bclk);
    for (int b = 0; b < nbits; b++) begin
      @(posedge i_clk);
      #1 o_line = frm[b];
      repeat (bclk - 1) @(posedge i_clk);
    end
    @(posedge i_clk);
    #1 o_line = 1'b1;
  endtask : send

  // Mid-bit sampling; returns at the stop sample so back-to-back frames are caught
  task automatic capture(input int nbits, input int bclk, output logic [10:0] frm, output logic ok);
    int n;
    frm = 11'h7FF;
    n = 0;
    while (i_line !== 1'b0 && n < 4000) begin
      @(posedge i_clk);
      n++;
    end
    ok = (n < 4000);
    repeat (bclk / 2) @(posedge i_clk);
    for (int b = 0; b < nbits; b++) begin
      frm[b] = i_line;
      if (b < nbits - 1) repeat (bclk) @(posedge i_clk);
    end
  endtask : capture
endmodule : fmsp_remote_node
`default_nettype wire

// >>> bench/test_fmsp_serial_port.sv
// Self-checking testbench of the four-mode serial port
`timescale 1ns/10ps
`default_nettype none
module test_fmsp_serial_port;
  import fmsp_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [1:0] i_mode = 2'h2;
  logic i_receive_enable = 1'b0;
  logic i_multiprocessor_filter_bit = 1'b0;
  logic i_transmit_ninth_bit = 1'b0;
  logic i_baud_double_bit = 1'b0;
  logic i_generator_select_bit = 1'b0;
  logic [7:0] i_prescaler_reload_low = 8'h00;
  logic [3:0] i_prescaler_reload_high = 4'h0;
  logic i_prescaler_load = 1'b0;
  logic i_timer1_overflow = 1'b0;
  logic i_data_wr = 1'b0;
  logic [7:0] i_data_wdata = 8'h00;
  logic i_receive_flag_clr = 1'b0;
  logic i_transmit_flag_clr = 1'b0;
  logic o_data_wr_ready, o_received_ninth_bit, o_receive_complete_flag, o_transmit_complete_flag;
  logic o_receive_overrun, o_rxd, o_rxd_oe, o_txd, node_line, i_rxd;
  logic [7:0] o_serial_data_buffer;
  int mismatches = 0;
  int comparisons = 0;
  int ovr_cnt = 0;

  always #10 i_ref_clk = ~i_ref_clk;
  // Shared data pin: whoever enables drives it
  assign i_rxd = o_rxd_oe ? o_rxd : node_line;
  always @(posedge i_ref_clk) if (o_receive_overrun === 1'b1) ovr_cnt++;

  fmsp_serial_port fmsp_serial_port_i (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_mode(i_mode),
    .i_receive_enable(i_receive_enable), .i_multiprocessor_filter_bit(i_multiprocessor_filter_bit),
    .i_transmit_ninth_bit(i_transmit_ninth_bit), .i_baud_double_bit(i_baud_double_bit),
    .i_generator_select_bit(i_generator_select_bit), .i_prescaler_reload_low(i_prescaler_reload_low),
    .i_prescaler_reload_high(i_prescaler_reload_high), .i_prescaler_load(i_prescaler_load),
    .i_timer1_overflow(i_timer1_overflow), .i_data_wr(i_data_wr), .i_data_wdata(i_data_wdata),
    .o_data_wr_ready(o_data_wr_ready), .o_serial_data_buffer(o_serial_data_buffer),
    .o_received_ninth_bit(o_received_ninth_bit), .o_receive_complete_flag(o_receive_complete_flag),
    .o_transmit_complete_flag(o_transmit_complete_flag), .i_receive_flag_clr(i_receive_flag_clr),
    .i_transmit_flag_clr(i_transmit_flag_clr), .o_receive_overrun(o_receive_overrun), .i_rxd(i_rxd),
    .o_rxd(o_rxd), .o_rxd_oe(o_rxd_oe), .o_txd(o_txd));
  fmsp_remote_node fmsp_remote_node_i (.i_clk(i_ref_clk), .i_line(o_txd), .o_line(node_line));

  task automatic chk(input logic c, input string msg);
    comparisons++;
    if (c !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic final_report;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  function automatic logic [10:0] mk(input logic [7:0] b, input logic n, input int nbits);
    return (nbits == 10) ? {2'b11, b, 1'b0} : {1'b1, n, b, 1'b0};
  endfunction : mk

  task automatic cfg(input logic [1:0] m, input logic dbl, input logic gsel, input logic tovf);
    @(posedge i_ref_clk);
    #1 {i_mode, i_baud_double_bit, i_generator_select_bit, i_timer1_overflow} = {m, dbl, gsel, tovf};
    repeat (4) @(posedge i_ref_clk);
  endtask : cfg

  task automatic wr(input logic [7:0] b, input logic n);
    @(posedge i_ref_clk);
    #1 {i_data_wr, i_data_wdata, i_transmit_ninth_bit} = {1'b1, b, n};
    do @(negedge i_ref_clk); while (o_data_wr_ready !== 1'b1);
    @(posedge i_ref_clk);
    #1 i_data_wr = 1'b0;
  endtask : wr

  // Clears only the flags asked for, so a parallel task keeps its own
  task automatic clear_flags(input logic rxc, input logic txc);
    @(posedge i_ref_clk);
    #1;
    if (rxc) i_receive_flag_clr = 1'b1;
    if (txc) i_transmit_flag_clr = 1'b1;
    @(posedge i_ref_clk);
    #1;
    if (rxc) i_receive_flag_clr = 1'b0;
    if (txc) i_transmit_flag_clr = 1'b0;
  endtask : clear_flags

  task automatic tx_check(input logic [7:0] b, input logic n, input int nbits, input int bclk);
    logic [10:0] frm;
    logic ok;
    fork
      wr(b, n);
      fmsp_remote_node_i.capture(nbits, bclk, frm, ok);
    join
    chk(ok && frm === mk(b, n, nbits), "transmitted frame wrong");
    repeat (bclk) @(posedge i_ref_clk);
    chk(o_transmit_complete_flag, "transmit flag not set");
    clear_flags(1'b0, 1'b1);
  endtask : tx_check

  task automatic rx_check(input logic [10:0] frm, input int nbits, input int bclk, input logic exp,
                          input logic [7:0] b, input logic n, input logic clr);
    fmsp_remote_node_i.send(frm, nbits, bclk);
    repeat (bclk) @(posedge i_ref_clk);
    chk(o_receive_complete_flag === exp, "receive flag wrong");
    if (exp) chk(o_serial_data_buffer === b && o_received_ninth_bit === n, "received word wrong");
    if (clr) clear_flags(1'b1, 1'b0);
  endtask : rx_check

  task automatic sc_reset;
    chk(o_txd === LINE_IDLE && o_rxd_oe === 1'b0 && o_data_wr_ready === 1'b1, "idle pins wrong");
    chk({o_receive_complete_flag, o_transmit_complete_flag} === 2'b00, "flags not clear");
  endtask : sc_reset

  task automatic sc_mode2;
    cfg(MODE_UART9_FIX, 1'b1, 1'b0, 1'b0);
    tx_check(8'hA5, 1'b1, 11, 16);
    cfg(MODE_UART9_FIX, 1'b0, 1'b0, 1'b0);
    tx_check(8'h5A, 1'b0, 11, 32);
  endtask : sc_mode2

  task automatic sc_mode1;
    cfg(MODE_UART8, 1'b1, 1'b0, 1'b1);
    #1 i_receive_enable = 1'b1;
    tx_check(8'h3C, 1'b0, 10, 16);
    rx_check(mk(8'hE1, 1'b0, 10), 10, 16, 1'b1, 8'hE1, 1'b1, 1'b1);
    #1 i_multiprocessor_filter_bit = 1'b1;
    rx_check({2'b00, 8'h77, 1'b0}, 10, 16, 1'b0, 8'h00, 1'b0, 1'b1);
    #1 i_multiprocessor_filter_bit = 1'b0;
  endtask : sc_mode1

  task automatic sc_mode3;
    #1 {i_prescaler_reload_high, i_prescaler_reload_low, i_prescaler_load} = {GEN_TOP, 1'b1};
    cfg(MODE_UART9_VAR, 1'b1, 1'b1, 1'b0);
    #1 i_prescaler_load = 1'b0;
    tx_check(8'hC3, 1'b1, 11, 16);
    rx_check(mk(8'h4B, 1'b0, 11), 11, 16, 1'b1, 8'h4B, 1'b0, 1'b1);
    #1 i_multiprocessor_filter_bit = 1'b1;
    rx_check(mk(8'h12, 1'b0, 11), 11, 16, 1'b0, 8'h00, 1'b0, 1'b1);
    rx_check(mk(8'h81, 1'b1, 11), 11, 16, 1'b1, 8'h81, 1'b1, 1'b1);
    #1 i_multiprocessor_filter_bit = 1'b0;
  endtask : sc_mode3

  task automatic sc_duplex_overrun;
    fork
      tx_check(8'h6D, 1'b0, 11, 16);
      rx_check(mk(8'h29, 1'b1, 11), 11, 16, 1'b1, 8'h29, 1'b1, 1'b0);
    join
    rx_check(mk(8'hD4, 1'b0, 11), 11, 16, 1'b1, 8'h29, 1'b1, 1'b1);
    chk(ovr_cnt == 1, "overrun not signalled once");
  endtask : sc_duplex_overrun

  task automatic sc_buffer;
    logic [10:0] f [3];
    logic ok [3];
    fork
      begin
        wr(8'h11, 1'b0);
        wr(8'h22, 1'b1);
        wr(8'h33, 1'b0);
        @(negedge i_ref_clk);
        chk(o_data_wr_ready === 1'b0, "buffer not full");
      end
      for (int k = 0; k < 3; k++) fmsp_remote_node_i.capture(11, 16, f[k], ok[k]);
    join
    chk(f[0] === mk(8'h11, 1'b0, 11) && f[1] === mk(8'h22, 1'b1, 11) && f[2] === mk(8'h33, 1'b0, 11),
        "buffered frames wrong");
    repeat (20) @(posedge i_ref_clk);
    clear_flags(1'b1, 1'b1);
  endtask : sc_buffer

  task automatic sc_mode0;
    logic [7:0] got;
    logic prev;
    int nb, per, last;
    nb = 0;
    per = 0;
    last = 0;
    prev = 1'b1;
    i_receive_enable = 1'b0;
    cfg(MODE_SHIFT, 1'b0, 1'b0, 1'b0);
    wr(8'h96, 1'b0);
    for (int c = 0; c < 300 && nb < 8; c++) begin
      @(posedge i_ref_clk);
      #1;
      if (prev === 1'b0 && o_txd === 1'b1 && o_rxd_oe === 1'b1) begin
        got[nb] = o_rxd;
        if (nb > 0) per = c - last;
        last = c;
        nb++;
      end
      prev = o_txd;
    end
    chk(nb == 8 && got === 8'h96, "shift data wrong");
    chk(per == 6, "shift period wrong");
    repeat (10) @(posedge i_ref_clk);
    chk(o_transmit_complete_flag, "shift transmit flag not set");
    clear_flags(1'b1, 1'b1);
    #1 i_receive_enable = 1'b1;
    repeat (70) @(posedge i_ref_clk);
    #1 i_receive_enable = 1'b0;
    chk(o_receive_complete_flag === 1'b1 && o_serial_data_buffer === 8'hFF, "shift receive wrong");
  endtask : sc_mode0

  initial begin
    #1_000_000;
    mismatches++;
    final_report;
  end

  initial begin
    repeat (10) @(posedge i_ref_clk);
    #1 i_reset_n = 1'b1;
    sc_reset;
    sc_mode2;
    sc_mode1;
    sc_mode3;
    sc_duplex_overrun;
    sc_buffer;
    sc_mode0;
    final_report;
  end
endmodule : test_fmsp_serial_port
`default_nettype wire
